// File: bjrd_defs.vh
`ifndef BJRD_DEFS_VH
`define BJRD_DEFS_VH
// jump sequence states (one per read cycle after restart)
`define BJRD_ST_OPCODE 2'b00
`define BJRD_ST_ADDR_LO 2'b01
`define BJRD_ST_ADDR_HI 2'b10
`define BJRD_ST_DONE 2'b11
// unconditional jump opcode and restart opcode base
`define BJRD_OP_JUMP 8'hc3
`define BJRD_OP_RESTART 8'hc7
// rom decode: compare top six address bits, 1K window
`define BJRD_ROM_MSB 15
`define BJRD_ROM_LSB 10
// wait cycles inserted per rom access
`define BJRD_ROM_WAIT_CYC 1
`endif

// File: bjrd_rom_decode.v
`timescale 1ns/1ps
`include "bjrd_defs.vh"
// =====================================================
// rom select decoder with one wait state
module bjrd_rom_decode (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // cpu cycle
    input wire [15:0] addr_i,
    input wire mem_rd_i,
    input wire cycle_start_i,
    input wire [5:0] base_i,
    // results
    output wire hit_o,
    output reg wait_o
);
    reg waited_q; // wait already served in this access
    // bitwise compare of the six high bits, memory reads only
    assign hit_o = mem_rd_i &&
        (addr_i[`BJRD_ROM_MSB:`BJRD_ROM_LSB] == base_i);
    // =====================================================
    // one wait cycle per access; cleared when a new cycle starts
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wait_o <= 1'b0;
            waited_q <= 1'b0;
        end else if (cycle_start_i) begin
            wait_o <= 1'b0;
            waited_q <= 1'b0;
        end else if (hit_o && !waited_q) begin
            wait_o <= 1'b1;
            waited_q <= 1'b1;
        end else begin
            wait_o <= 1'b0; // other memory runs at full speed
        end
    end
endmodule // bjrd_rom_decode

// File: bjrd_boot_jump.v
`timescale 1ns/1ps
`include "bjrd_defs.vh"
// What this block does
// - jump to jumper address after reset
// - restart clears sequence counter to first state
// - advance one state per read, four states
// - fourth state flags done and holds
// - done suppresses injection until next restart
// - first three states drive jump bytes
// - opcode from interrupt generator in jump mode
// - byte select picks target bytes, states two-three
// - auto-jump removable by build option
// - rom base on any 1K boundary
// - rom enable on reads matching six bits
// - rom access gets a wait state
// - rom drives data bus, receivers off
module bjrd_boot_jump #(
    parameter AUTO_JUMP_EN = 1 // build option: 0 omits the auto-jump
) (
    // clock and reset (reset is the restart condition)
    input wire clk_sys_i,
    input wire rst_n_i,
    // cpu cycle, asynchronous to this clock, synchronised here
    input wire [15:0] addr_i,
    input wire mem_rd_i,
    input wire rd_i,
    input wire int_ack_i,
    // jumper settings
    input wire [15:0] jump_target_i,
    input wire [5:0] rom_base_i,
    // data sources
    input wire [7:0] ext_data_i,
    input wire [7:0] rom_data_i,
    input wire [2:0] int_level_i,
    // outputs to cpu
    output reg [7:0] cpu_data_bus_o,
    output reg local_rom_enable_o,
    output reg ext_rx_enable_o,
    output reg cpu_ready_o,
    output reg jump_sequence_done_o,
    output reg target_byte_select_o
);
    // =====================================================
    // timing overview
    // every pin but rst_n_i passes two flip-flops before logic reads it, and every
    // output is registered, so the data bus and enables react on the third
    // edge after the pin that caused it; jump_sequence_done_o, target_byte_select_o
    // and cpu_ready_o react later. the cpu holds its read strobe for several of
    // our clocks, so this delay costs nothing but latency.
    // a read cycle is seen twice: its rising edge restarts the rom wait
    // logic, and its falling edge moves the jump counter on. advancing at
    // the end keeps the injected byte steady for the whole read, at the
    // price of one idle gap being needed between two reads.
    // the injected jump wins over the rom: a rom placed over the restart
    // address would otherwise answer the first fetch instead of the jump.
    // the shared byte generator answers interrupt acknowledge only once the
    // jump is done, so a stray acknowledge during boot cannot corrupt it.
    // =====================================================
    // input synchronisers: first stage read only by second
    reg [15:0] addr_m_q, addr_s_q;
    reg mem_rd_m_q, mem_rd_s_q, rd_m_q, rd_s_q, inta_m_q, inta_s_q;
    reg rd_prev_q; // for read-cycle edge detect
    reg [1:0] state_q; // jump sequence counter
    reg [1:0] state_d;
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            addr_m_q <= 16'h0000;
            addr_s_q <= 16'h0000;
            mem_rd_m_q <= 1'b0;
            mem_rd_s_q <= 1'b0;
            rd_m_q <= 1'b0;
            rd_s_q <= 1'b0;
            inta_m_q <= 1'b0;
            inta_s_q <= 1'b0;
            rd_prev_q <= 1'b0;
        end else begin
            addr_m_q <= addr_i;
            addr_s_q <= addr_m_q;
            mem_rd_m_q <= mem_rd_i;
            mem_rd_s_q <= mem_rd_m_q;
            rd_m_q <= rd_i;
            rd_s_q <= rd_m_q;
            inta_m_q <= int_ack_i;
            inta_s_q <= inta_m_q;
            rd_prev_q <= rd_s_q;
        end
    end
    wire rd_start = rd_s_q && !rd_prev_q; // one pulse per read cycle
    wire rd_end = !rd_s_q && rd_prev_q; // read cycle finished
    // =====================================================
    // jumper and data synchronisers
    // jumpers are static in use, but they are still pins: they pass the same
    // two stages as the cpu strobes, so a jumper moved while running can
    // never feed a half-settled value into the byte mux or the rom compare
    reg [15:0] target_m_q, target_s_q; // jump target
    reg [5:0] base_m_q, base_s_q; // rom base
    reg [7:0] ext_m_q, ext_s_q; // external read data
    reg [7:0] romd_m_q, romd_s_q; // rom read data
    reg [2:0] level_m_q, level_s_q; // interrupt level
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            // constants only, so reset never depends on a pin
            target_m_q <= 16'h0000;
            target_s_q <= 16'h0000;
            base_m_q <= 6'h00;
            base_s_q <= 6'h00;
            ext_m_q <= 8'h00;
            ext_s_q <= 8'h00;
            romd_m_q <= 8'h00;
            romd_s_q <= 8'h00;
            level_m_q <= 3'h0;
            level_s_q <= 3'h0;
        end else begin
            // first stage is read only by the second
            target_m_q <= jump_target_i;
            target_s_q <= target_m_q;
            base_m_q <= rom_base_i;
            base_s_q <= base_m_q;
            ext_m_q <= ext_data_i;
            ext_s_q <= ext_m_q;
            romd_m_q <= rom_data_i;
            romd_s_q <= romd_m_q;
            level_m_q <= int_level_i;
            level_s_q <= level_m_q;
        end
    end
    // =====================================================
    // sequence counter; a build without the option goes to done on the first clock after restart
    wire aj_on = (AUTO_JUMP_EN != 0);
    always @* begin
        state_d = state_q;
        if (!aj_on)
            state_d = `BJRD_ST_DONE;
        else if (rd_end && state_q != `BJRD_ST_DONE)
            state_d = state_q + 2'b01; // advance after each read
    end
    always @(posedge clk_sys_i) begin
        if (!rst_n_i)
            state_q <= `BJRD_ST_OPCODE; // restart begins again
        else
            state_q <= state_d;
    end
    wire done = (state_q == `BJRD_ST_DONE);
    wire inject = !done && rd_s_q;
    wire sel_addr = (state_q == `BJRD_ST_ADDR_LO) || (state_q == `BJRD_ST_ADDR_HI);
    // =====================================================
    // rom decoder: wait resets on each new read cycle
    wire rom_hit;
    wire rom_wait;
    bjrd_rom_decode u_rom (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .addr_i(addr_s_q),
        .mem_rd_i(mem_rd_s_q),
        .cycle_start_i(rd_start),
        .base_i(base_s_q),
        .hit_o(rom_hit),
        .wait_o(rom_wait)
    );
    // shared byte generator: restart opcode or jump opcode
    wire [7:0] vec_byte = (inta_s_q && done) ?
        (`BJRD_OP_RESTART | {2'b00, level_s_q, 3'b000}) : `BJRD_OP_JUMP;
    // =====================================================
    // data mux and registered outputs
    reg [7:0] data_d;
    always @* begin
        if (inject) begin
            case (state_q)
                `BJRD_ST_OPCODE: data_d = vec_byte;
                `BJRD_ST_ADDR_LO: data_d = target_s_q[7:0];
                `BJRD_ST_ADDR_HI: data_d = target_s_q[15:8];
                default: data_d = ext_s_q; // unreachable while injecting
            endcase
        end else if (inta_s_q) begin
            // acknowledge after boot: restart opcode from the generator
            data_d = vec_byte;
        end else if (rom_hit) begin
            data_d = romd_s_q; // rom drives the bus directly
        end else begin
            // plain read, or idle: the external bus is passed through
            data_d = ext_s_q;
        end
    end
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cpu_data_bus_o <= 8'h00;
            local_rom_enable_o <= 1'b0;
            ext_rx_enable_o <= 1'b0;
            cpu_ready_o <= 1'b1;
            jump_sequence_done_o <= 1'b0;
            target_byte_select_o <= 1'b0;
        end else begin
            cpu_data_bus_o <= data_d;
            local_rom_enable_o <= rom_hit && !inject;
            // receivers only for external reads, never rom or injected bytes
            ext_rx_enable_o <= rd_s_q && !rom_hit && !inject && !inta_s_q;
            cpu_ready_o <= !(rom_wait && !inject);
            jump_sequence_done_o <= done;
            target_byte_select_o <= sel_addr && aj_on;
        end
    end
endmodule // bjrd_boot_jump

// File: bjrd_chk.sv
`timescale 1ns/1ps
// ====
// port checker: latency 3 edges from a cpu input to an output
module bjrd_chk (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // cpu inputs
    input wire [15:0] addr_i,
    input wire mem_rd_i,
    input wire [5:0] rom_base_i,
    input wire [7:0] rom_data_i,
    // outputs
    input wire [7:0] cpu_data_bus_o,
    input wire local_rom_enable_o,
    input wire ext_rx_enable_o,
    input wire cpu_ready_o,
    input wire jump_sequence_done_o,
    input wire target_byte_select_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // reset checked with no disable, it is the cause here
    a_restart_clears: assert property (disable iff (1'b0) !rst_n_i |=> cpu_ready_o &&
        !jump_sequence_done_o && !target_byte_select_o) else $error("restart state");
    a_done_holds: assert property (jump_sequence_done_o |=> jump_sequence_done_o)
        else $error("done dropped");
    a_done_after_sel: assert property ($fell(target_byte_select_o) |-> ##[0:4]
        jump_sequence_done_o) else $error("no done after bytes");
    a_done_no_sel: assert property (jump_sequence_done_o |-> !target_byte_select_o)
        else $error("select while done");
    a_rx_after_done: assert property (ext_rx_enable_o |-> jump_sequence_done_o)
        else $error("external read during jump");
    a_rom_decode: assert property (local_rom_enable_o |-> $past(mem_rd_i, 3) &&
        $past(addr_i[15:10], 3) == rom_base_i) else $error("rom enable without match");
    a_rom_rx_off: assert property (local_rom_enable_o |-> !ext_rx_enable_o
        && cpu_data_bus_o == rom_data_i) else $error("rom data path");
    a_wait_one: assert property ($fell(cpu_ready_o) |=> cpu_ready_o)
        else $error("wait not one cycle");
    a_wait_rom_only: assert property ($fell(cpu_ready_o) |-> local_rom_enable_o
        || $past(local_rom_enable_o)) else $error("wait outside rom");
    // main scenarios reached
    c_done: cover property ($rose(jump_sequence_done_o));
    c_rom: cover property ($rose(local_rom_enable_o));
    c_wait: cover property ($fell(cpu_ready_o));
endmodule // bjrd_chk
bind bjrd_boot_jump bjrd_chk u_bjrd_chk (.clk_sys_i, .rst_n_i, .addr_i, .mem_rd_i,
    .rom_base_i, .rom_data_i, .cpu_data_bus_o, .local_rom_enable_o, .ext_rx_enable_o,
    .cpu_ready_o, .jump_sequence_done_o, .target_byte_select_o);

// File: bjrd_cpu_model.sv
`timescale 1ns/1ps
// ====
// cpu model: one read per call, twice the minimum rd spacing
module bjrd_cpu_model (
    // clock and answers
    input wire clk_sys_i,
    input wire [7:0] cpu_data_bus_i,
    input wire cpu_ready_i,
    // cpu cycle
    output reg [15:0] addr_o,
    output reg mem_rd_o,
    output reg rd_o
);
    reg [15:0] waits; // ready low cycles in the last read
    initial begin
        addr_o = 16'h0000;
        mem_rd_o = 1'b0;
        rd_o = 1'b0;
    end
    // released address inverted so a stale value never matches
    task read(input [15:0] a, input m, output [7:0] d);
        integer i;
        begin
            waits = 16'h0000;
            @(posedge clk_sys_i);
            addr_o <= a;
            mem_rd_o <= m;
            rd_o <= 1'b1;
            for (i = 0; i < 6; i = i + 1) begin
                @(posedge clk_sys_i);
                if (cpu_ready_i === 1'b0) waits = waits + 16'h0001;
            end
            d = cpu_data_bus_i;
            rd_o <= 1'b0;
            mem_rd_o <= 1'b0;
            addr_o <= ~a;
            repeat (6) @(posedge clk_sys_i);
        end
    endtask
endmodule // bjrd_cpu_model

// File: boot_jump_and_rom_decode_tb.sv
`timescale 1ns/1ps
module boot_jump_and_rom_decode_tb;
    // ====
    // stimulus and outputs
    reg clk_sys_i = 1'b0, rst_n_i = 1'b0;
    reg [15:0] jump_target_i = 16'h7e21;
    reg [5:0] rom_base_i = 6'h2d; // window b400..b7ff
    reg [7:0] ext_data_i = 8'h5a, rom_data_i = 8'ha5;
    wire [15:0] addr_i;
    wire mem_rd_i, rd_i, local_rom_enable_o, ext_rx_enable_o, cpu_ready_o;
    wire jump_sequence_done_o, target_byte_select_o;
    wire [7:0] cpu_data_bus_o;
    integer n_fail = 0, samples_checked = 0, cyc = 0;
    integer n_rom = 0, n_rx = 0, r0, x0; // enable-high cycle counts
    reg [7:0] d;
    integer i;
    bjrd_boot_jump u_bjrd_boot_jump (.clk_sys_i, .rst_n_i, .addr_i, .mem_rd_i, .rd_i,
        .int_ack_i(1'b0), .jump_target_i, .rom_base_i, .ext_data_i, .rom_data_i,
        .int_level_i(3'h0), .cpu_data_bus_o, .local_rom_enable_o, .ext_rx_enable_o,
        .cpu_ready_o, .jump_sequence_done_o, .target_byte_select_o);
    bjrd_cpu_model u_bjrd_cpu_model (.clk_sys_i, .cpu_data_bus_i(cpu_data_bus_o),
        .cpu_ready_i(cpu_ready_o), .addr_o(addr_i), .mem_rd_o(mem_rd_i), .rd_o(rd_i));
    initial forever #2 clk_sys_i = ~clk_sys_i;
    // hang guard, far above the roughly 160 cycles needed
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (local_rom_enable_o === 1'b1) n_rom <= n_rom + 1;
        if (ext_rx_enable_o === 1'b1) n_rx <= n_rx + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    end
    task chk(input [95:0] nm, input [15:0] e, input [15:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("ERROR %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task restart;
        begin
            rst_n_i <= 1'b0;
            repeat (6) @(posedge clk_sys_i);
            rst_n_i <= 1'b1;
        end
    endtask
    // five reads: jump bytes, then plain reads once done
    task t_jump;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                x0 = n_rx;
                u_bjrd_cpu_model.read(16'h0010, 1'b1, d);
                chk("jump byte", i == 0 ? 8'hc3 : i == 1 ? 8'h21 : i == 2 ? 8'h7e : 8'h5a, d);
                chk("select", i < 2, target_byte_select_o);
                chk("rx enable", i > 2, n_rx != x0);
            end
            chk("done", 1'b1, jump_sequence_done_o);
        end
    endtask
    // window edges hit, next 1K misses, io read in the 1K after that misses
    task t_rom;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                r0 = n_rom;
                x0 = n_rx;
                u_bjrd_cpu_model.read(16'hb400 + i[15:0] * 16'h03ff, i != 3, d);
                chk("rom data", i < 2 ? 8'ha5 : 8'h5a, d);
                chk("waits", i < 2, u_bjrd_cpu_model.waits);
                chk("rom enable", i < 2, n_rom != r0);
                chk("rx enable", i > 1, n_rx != x0);
            end
        end
    endtask
    // restart mid-sequence begins again at the opcode
    task t_restart;
        begin
            restart;
            u_bjrd_cpu_model.read(16'h0000, 1'b1, d);
            chk("select", 1'b1, target_byte_select_o);
            restart;
            chk("done", 1'b0, jump_sequence_done_o);
            chk("select", 1'b0, target_byte_select_o);
            u_bjrd_cpu_model.read(16'h0000, 1'b1, d);
            chk("restart byte", 8'hc3, d);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        @(posedge clk_sys_i);
        restart;
        t_jump;
        t_rom;
        t_restart;
        tally_and_finish;
    end
endmodule // boot_jump_and_rom_decode_tb
